/* design/csa_shifter.sv */
`timescale 1ns/10ps
module csa_shifter
    import csa_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    csa_shift_if.shift sif,
    input wire logic sck_pin,
    input wire logic si_pin,
    output logic so_pin
);
    logic sck_meta;
    logic sck_sync;
    logic sck_last;
    logic si_meta;
    logic si_sync;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] rx_q;
    logic [7:0] next_rx;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic active;
    logic next_active;
    logic done_q;
    logic next_done;
    logic next_so;
    logic rise;
    logic fall;
    logic first_bit;

    // The partner owns the serial clock, so it is only sampled and its edges found here.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sck_meta <= 1'b1;
            sck_sync <= 1'b1;
            sck_last <= 1'b1;
            si_meta <= 1'b1;
            si_sync <= 1'b1;
        end else begin
            sck_meta <= sck_pin;
            sck_sync <= sck_meta;
            sck_last <= sck_sync;
            si_meta <= si_pin;
            si_sync <= si_meta;
        end
    end

    assign rise = sck_sync & ~sck_last;
    assign fall = ~sck_sync & sck_last;
    assign first_bit = sif.tx_en ? sif.tx_byte[7] : 1'b1;

    always_comb begin
        next_shreg = shreg;
        next_rx = rx_q;
        next_cnt = cnt;
        next_active = active;
        next_done = 1'b0;
        next_so = so_pin;
        if (sif.clear) begin
            next_active = 1'b0;
            next_cnt = 4'h0;
            next_so = 1'b1;
        end else if (sif.start) begin
            next_shreg = sif.tx_en ? sif.tx_byte : IDLE_FILL;
            next_so = first_bit;
            next_cnt = 4'h0;
            next_active = 1'b1;
        end else if (active) begin
            if (rise) begin
                next_shreg = {shreg[6:0], si_sync};
                next_cnt = cnt + 4'h1;
                if (cnt == LAST_BIT_INDEX) begin
                    next_active = 1'b0;
                    next_done = 1'b1;
                    next_rx = {shreg[6:0], si_sync};
                end
            end else if (fall) begin
                next_so = sif.tx_en ? shreg[7] : 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            shreg <= BYTE_ZERO;
            rx_q <= BYTE_ZERO;
            cnt <= 4'h0;
            active <= 1'b0;
            done_q <= 1'b0;
            so_pin <= 1'b1;
        end else begin
            shreg <= next_shreg;
            rx_q <= next_rx;
            cnt <= next_cnt;
            active <= next_active;
            done_q <= next_done;
            so_pin <= next_so;
        end
    end

    assign sif.rx_byte = rx_q;
    assign sif.done = done_q;

    a_first_bit_out: assert property (@(posedge clock) disable iff (reset)
        sif.start && !sif.clear |=> so_pin == $past(first_bit) && active)
        else $error("first serial bit not presented after start");
    a_done_after_eight: assert property (@(posedge clock) disable iff (reset)
        done_q |-> !active && $past(cnt) == LAST_BIT_INDEX && $past(active))
        else $error("byte done without eight clock edges");
endmodule

/* design/csa_top.sv */
`timescale 1ns/10ps
// Behaviour
// - Writing the shift register starts a serial transfer with no further trigger.
// - While the unit is disabled, every buffer RAM access is blocked.
// - Clearing the unit enable resets the dependent registers, which software then programs again.
// - Buffer RAM contents are kept unchanged after the unit is disabled and enabled again.
// - While busy, writes that change mode, divisor, auto_last, interval or shift are rejected.
// - A start or stop trigger acts only once the byte being shifted has completed.
// - Start and stop triggers clear themselves when the transfer complete interrupt is raised.
module csa_top (
    input wire logic clock,
    input wire logic reset,
    input wire logic [csa_pkg::ADDR_W-1:0] addr,
    input wire logic [csa_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [csa_pkg::DATA_W-1:0] rdata,
    input wire logic sck_pin,
    input wire logic si_pin,
    output logic so_pin,
    output logic irq
);
    import csa_pkg::*;

    csa_shift_if sif ();

    csa_state_t state;
    csa_state_t next_state;
    logic [7:0] mode;
    logic [7:0] next_mode;
    logic [7:0] divisor;
    logic [7:0] next_divisor;
    logic [4:0] auto_last;
    logic [4:0] next_auto_last;
    logic [7:0] interval;
    logic [7:0] next_interval;
    logic [7:0] shift_tx;
    logic [7:0] next_shift_tx;
    logic [1:0] trig;
    logic [1:0] next_trig;
    logic [1:0] irq_stat;
    logic [1:0] next_irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] next_irq_mask;
    logic [4:0] buf_ptr;
    logic [4:0] next_buf_ptr;
    logic [4:0] auto_ptr;
    logic [4:0] next_auto_ptr;
    logic [7:0] next_rdata;
    logic next_irq;
    logic [7:0] mem [0:BUF_DEPTH-1];
    logic mem_we;
    logic [4:0] mem_wa;
    logic [7:0] mem_wd;
    logic busy;
    logic unit_en;
    logic unit_drop;
    logic start_now;
    logic evt_byte;
    logic evt_auto;
    logic wr_mode;

    assign busy = (state != ST_IDLE);
    assign unit_en = mode[MODE_EN_BIT];
    assign wr_mode = wr && addr == REG_MODE && (!busy || wdata == mode);
    assign unit_drop = wr_mode && unit_en && !wdata[MODE_EN_BIT];

    csa_shifter u_shifter (
        .clock(clock),
        .reset(reset),
        .sif(sif.shift),
        .sck_pin(sck_pin),
        .si_pin(si_pin),
        .so_pin(so_pin)
    );

    assign sif.start = start_now;
    assign sif.clear = ~unit_en;
    assign sif.tx_en = mode[MODE_TX_BIT];
    assign sif.tx_byte = (state == ST_LOAD) ? mem[auto_ptr] : next_shift_tx;

    // Transfer sequencing and the single and automatic engines.
    always_comb begin
        next_state = state;
        next_shift_tx = shift_tx;
        next_auto_ptr = auto_ptr;
        start_now = 1'b0;
        evt_byte = 1'b0;
        evt_auto = 1'b0;
        mem_we = 1'b0;
        mem_wa = buf_ptr;
        mem_wd = wdata;
        case (state)
            ST_IDLE: begin
                if (wr && addr == REG_SHIFT && unit_en) begin
                    next_shift_tx = wdata;
                    start_now = 1'b1;
                    next_state = ST_SINGLE;
                end else if (trig[TRIG_START_BIT] && unit_en) begin
                    next_auto_ptr = PTR_RST;
                    next_state = ST_LOAD;
                end
            end
            ST_SINGLE: begin
                if (sif.done) begin
                    evt_byte = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_LOAD: begin
                start_now = 1'b1;
                next_state = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (sif.done) begin
                    evt_byte = 1'b1;
                    mem_we = 1'b1;
                    mem_wa = auto_ptr;
                    mem_wd = sif.rx_byte;
                    if (trig[TRIG_STOP_BIT] || auto_ptr == auto_last) begin
                        evt_auto = 1'b1;
                        next_state = ST_IDLE;
                    end else begin
                        next_auto_ptr = auto_ptr + 5'h01;
                        next_state = ST_LOAD;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!mem_we && wr && addr == REG_BUF_DATA && unit_en) begin
            mem_we = 1'b1;
        end
        if (unit_drop) begin
            next_state = ST_IDLE;
            next_shift_tx = BYTE_ZERO;
            next_auto_ptr = PTR_RST;
            start_now = 1'b0;
            mem_we = 1'b0;
        end
    end

    // Register writes; a busy unit only accepts rewrites of the current value for mode, divisor, auto_last and interval.
    always_comb begin
        next_mode = mode;
        next_divisor = divisor;
        next_auto_last = auto_last;
        next_interval = interval;
        next_trig = trig;
        next_irq_mask = irq_mask;
        next_buf_ptr = buf_ptr;
        next_irq_stat = irq_stat;
        if (wr_mode) begin
            next_mode = wdata;
        end
        if (wr && addr == REG_DIVISOR && (!busy || wdata == divisor)) begin
            next_divisor = wdata;
        end
        if (wr && addr == REG_AUTO_LAST && (!busy || wdata[4:0] == auto_last)) begin
            next_auto_last = wdata[4:0];
        end
        if (wr && addr == REG_INTERVAL && (!busy || wdata == interval)) begin
            next_interval = wdata;
        end
        if (wr && addr == REG_TRIGGER) begin
            next_trig = wdata[1:0];
        end
        if (wr && addr == REG_IRQ_MASK) begin
            next_irq_mask = wdata[1:0];
        end
        if (wr && addr == REG_BUF_ADDR && unit_en) begin
            next_buf_ptr = wdata[4:0];
        end else if ((wr || rd) && addr == REG_BUF_DATA && unit_en) begin
            next_buf_ptr = buf_ptr + 5'h01;
        end
        if (wr && addr == REG_IRQ_STATUS) begin
            next_irq_stat = irq_stat & ~wdata[1:0];
        end
        // A new event wins over a clear in the same cycle.
        if (evt_byte) begin
            next_irq_stat[IRQ_BYTE_BIT] = 1'b1;
        end
        if (evt_auto) begin
            next_irq_stat[IRQ_AUTO_BIT] = 1'b1;
            next_trig = TRIG_RST;
        end
        if (unit_drop) begin
            next_divisor = BYTE_ZERO;
            next_auto_last = PTR_RST;
            next_interval = BYTE_ZERO;
            next_trig = TRIG_RST;
            next_buf_ptr = PTR_RST;
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // Read data for the cycle after the strobe; status bit 7 is reserved and reads zero.
    always_comb begin
        next_rdata = BYTE_ZERO;
        if (rd) begin
            case (addr)
                REG_MODE: next_rdata = mode;
                REG_STATUS: next_rdata = {6'h00, (state == ST_LOAD || state == ST_SHIFT), busy};
                REG_DIVISOR: next_rdata = divisor;
                REG_AUTO_LAST: next_rdata = {3'h0, auto_last};
                REG_INTERVAL: next_rdata = interval;
                REG_SHIFT: next_rdata = sif.rx_byte;
                REG_TRIGGER: next_rdata = {6'h00, trig};
                REG_IRQ_STATUS: next_rdata = {6'h00, irq_stat};
                REG_IRQ_MASK: next_rdata = {6'h00, irq_mask};
                REG_BUF_ADDR: next_rdata = {3'h0, buf_ptr};
                REG_BUF_DATA: next_rdata = unit_en ? mem[buf_ptr] : BYTE_ZERO;
                REG_AUTO_COUNT: next_rdata = {3'h0, auto_ptr};
                default: next_rdata = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            mode <= BYTE_ZERO;
            divisor <= BYTE_ZERO;
            auto_last <= PTR_RST;
            interval <= BYTE_ZERO;
            shift_tx <= BYTE_ZERO;
            trig <= TRIG_RST;
            irq_stat <= IRQ_RST;
            irq_mask <= IRQ_RST;
            buf_ptr <= PTR_RST;
            auto_ptr <= PTR_RST;
            rdata <= BYTE_ZERO;
            irq <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            divisor <= next_divisor;
            auto_last <= next_auto_last;
            interval <= next_interval;
            shift_tx <= next_shift_tx;
            trig <= next_trig;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            buf_ptr <= next_buf_ptr;
            auto_ptr <= next_auto_ptr;
            rdata <= next_rdata;
            irq <= next_irq;
        end
    end

    // The buffer has no reset, and a disable leaves its contents as they were.
    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    a_write_starts_busy: assert property (@(posedge clock) disable iff (reset)
        wr && addr == REG_SHIFT && unit_en && !busy |=> busy ##0 state == ST_SINGLE)
        else $error("shift register write did not start a transfer");
    a_shift_rejected_auto: assert property (@(posedge clock) disable iff (reset)
        wr && addr == REG_SHIFT && (state == ST_SHIFT || state == ST_LOAD) |=> $stable(shift_tx))
        else $error("shift register changed during automatic transfer");
    a_buf_read_blocked: assert property (@(posedge clock) disable iff (reset)
        rd && addr == REG_BUF_DATA && !unit_en |=> rdata == BYTE_ZERO && $stable(buf_ptr))
        else $error("buffer reachable while unit disabled");
    a_disable_clears: assert property (@(posedge clock) disable iff (reset)
        $fell(unit_en) |-> divisor == BYTE_ZERO && trig == TRIG_RST && !busy && auto_last == PTR_RST)
        else $error("dependent registers kept after unit disable");
    a_busy_locks_div: assert property (@(posedge clock) disable iff (reset)
        busy && wr && addr == REG_DIVISOR && wdata != divisor |=> $stable(divisor))
        else $error("divisor changed while busy");
    a_busy_locks_mode: assert property (@(posedge clock) disable iff (reset)
        busy && wr && addr == REG_MODE && wdata != mode |=> $stable(mode))
        else $error("mode changed while busy");
    a_stop_waits_byte: assert property (@(posedge clock) disable iff (reset)
        state == ST_SHIFT && trig[TRIG_STOP_BIT] && !sif.done && unit_en |=> state == ST_SHIFT)
        else $error("stop acted before the byte completed");
    a_trig_self_clear: assert property (@(posedge clock) disable iff (reset)
        evt_auto |=> trig == TRIG_RST && irq_stat[IRQ_AUTO_BIT])
        else $error("triggers not cleared with completion interrupt");
    a_busy_holds: assert property (@(posedge clock) disable iff (reset)
        busy && !sif.done && unit_en && !unit_drop |=> busy)
        else $error("busy dropped before the last bit");
    a_busy_ends: assert property (@(posedge clock) disable iff (reset)
        state == ST_SINGLE && sif.done |=> !busy ##0 irq_stat[IRQ_BYTE_BIT])
        else $error("busy not cleared after last bit");
    a_busy_locks_ivl: assert property (@(posedge clock) disable iff (reset)
        busy && wr && addr == REG_INTERVAL && wdata != interval |=> $stable(interval))
        else $error("interval changed while busy");
    a_buf_write_blocked: assert property (@(posedge clock) disable iff (reset)
        !unit_en |-> !mem_we)
        else $error("buffer written while unit disabled");
endmodule

/* inc/csa_pkg.sv */
package csa_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int BUF_AW = 5;
    localparam int BUF_DEPTH = 32;

    localparam logic [3:0] REG_MODE = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_DIVISOR = 4'h2;
    localparam logic [3:0] REG_AUTO_LAST = 4'h3;
    localparam logic [3:0] REG_INTERVAL = 4'h4;
    localparam logic [3:0] REG_SHIFT = 4'h5;
    localparam logic [3:0] REG_TRIGGER = 4'h6;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h7;
    localparam logic [3:0] REG_IRQ_MASK = 4'h8;
    localparam logic [3:0] REG_BUF_ADDR = 4'h9;
    localparam logic [3:0] REG_BUF_DATA = 4'hA;
    localparam logic [3:0] REG_AUTO_COUNT = 4'hB;

    localparam int MODE_EN_BIT = 7;
    localparam int MODE_TX_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_AUTO_BIT = 1;
    localparam int TRIG_START_BIT = 0;
    localparam int TRIG_STOP_BIT = 1;
    localparam int IRQ_BYTE_BIT = 0;
    localparam int IRQ_AUTO_BIT = 1;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] IDLE_FILL = 8'hFF;
    localparam logic [3:0] LAST_BIT_INDEX = 4'h7;
    localparam logic [1:0] TRIG_RST = 2'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [4:0] PTR_RST = 5'h00;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SINGLE = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_SHIFT = 4'b1000
    } csa_state_t;
endpackage

/* inc/csa_shift_if.sv */
`timescale 1ns/10ps
interface csa_shift_if;
    logic start;
    logic clear;
    logic tx_en;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic done;
    modport ctrl (output start, output clear, output tx_en, output tx_byte, input rx_byte, input done);
    modport shift (input start, input clear, input tx_en, input tx_byte, output rx_byte, output done);
endinterface

/* verification/csa_partner.sv */
`timescale 1ns/10ps
module csa_partner (
    input wire logic so_pin,
    output logic sck_pin,
    output logic si_pin
);
    initial begin
        sck_pin = 1'b1;
        si_pin = 1'b1;
    end

    // Frames are clocked by hand, so the link clock stands high between bytes.
    // The lead-in gap gives the device time to present its first bit.
    // Its odd length keeps pin changes away from the rising edges of the system clock.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #410;
        for (int i = 7; i >= 0; i--) begin
            sck_pin = 1'b0;
            si_pin = tx[i];
            #100;
            sck_pin = 1'b1;
            rx[i] = so_pin;
            #100;
        end
        // A released data line shows the inverse, so a stale bit never passes for data.
        si_pin = ~si_pin;
    endtask
endmodule

/* verification/test_csa_top.sv */
`timescale 1ns/10ps
module test_csa_top;
    import csa_pkg::*;
    logic clock;
    logic reset;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic sck_pin;
    logic si_pin;
    logic so_pin;
    logic irq;
    int err_count;
    int check_count;
    logic [7:0] seed;
    logic [7:0] div;
    logic [7:0] v;
    logic [7:0] tx;
    logic [7:0] got;
    logic [7:0] bufv [3];
    logic [7:0] rxv [3];

    csa_top csa_top_i (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sck_pin(sck_pin), .si_pin(si_pin), .so_pin(so_pin), .irq(irq));
    csa_partner csa_partner_i (.so_pin(so_pin), .sck_pin(sck_pin), .si_pin(si_pin));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // With transmit disabled the device must send all ones.
    function automatic logic [7:0] exp_out(input logic tx_on, input logic [7:0] b);
        return tx_on ? b : IDLE_FILL;
    endfunction

    task automatic results;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
            err_count++;
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_idle;
        logic [7:0] s;
        for (int n = 0; n < 200; n++) begin
            rd_reg(REG_STATUS, s);
            if (s[STAT_BUSY_BIT] === 1'b0)
                return;
        end
        $display("mismatch at %0t: got %h expected %h", $time, s, 8'h00);
        err_count++;
        results();
    endtask

    task automatic single(input logic tx_on);
        logic [7:0] t;
        logic [7:0] r;
        logic [7:0] g;
        t = seed;
        seed = lfsr(seed);
        r = seed;
        seed = lfsr(seed);
        wr_reg(REG_MODE, tx_on ? 8'h88 : 8'h80);
        wr_reg(REG_SHIFT, t);
        rd_reg(REG_STATUS, g);
        check(g & 8'h03, 8'h01);
        wr_reg(REG_DIVISOR, ~div);
        wr_reg(REG_INTERVAL, div);
        wr_reg(REG_MODE, tx_on ? 8'h80 : 8'h88);
        wr_reg(REG_SHIFT, ~t);
        csa_partner_i.xfer(r, g);
        check(g, exp_out(tx_on, t));
        wait_idle();
        rd_reg(REG_DIVISOR, g);
        check(g, div);
        rd_reg(REG_INTERVAL, g);
        check(g, ~div);
        rd_reg(REG_SHIFT, g);
        check(g, r);
        check({7'h00, irq}, 8'h01);
        wr_reg(REG_IRQ_STATUS, 8'h01);
        @(posedge clock);
        #1;
        check({7'h00, irq}, 8'h00);
    endtask

    initial begin
        #1000000;
        err_count++;
        results();
    end

    initial begin
        err_count = 0;
        check_count = 0;
        seed = 8'h0b;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        reset = 1'b1;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        rd_reg(REG_MODE, v);
        check(v, 8'h00);
        rd_reg(4'hC, v);
        check(v, 8'h00);
        wr_reg(REG_BUF_ADDR, 8'h00);
        wr_reg(REG_BUF_DATA, 8'h5a);
        rd_reg(REG_BUF_DATA, v);
        check(v, 8'h00);
        wr_reg(REG_SHIFT, 8'h3c);
        rd_reg(REG_STATUS, v);
        check(v, 8'h00);
        wr_reg(REG_MODE, 8'h88);
        wr_reg(REG_IRQ_MASK, 8'h03);
        div = 8'h5a;
        wr_reg(REG_DIVISOR, div);
        wr_reg(REG_INTERVAL, ~div);
        wr_reg(REG_STATUS, 8'h00);
        for (int i = 0; i < 6; i++)
            single(i < 4);
        // Automatic run requested while a single byte is still shifting.
        wr_reg(REG_MODE, 8'h88);
        wr_reg(REG_AUTO_LAST, 8'h02);
        wr_reg(REG_BUF_ADDR, 8'h00);
        for (int k = 0; k < 3; k++) begin
            bufv[k] = seed;
            seed = lfsr(seed);
            wr_reg(REG_BUF_DATA, bufv[k]);
        end
        tx = seed;
        seed = lfsr(seed);
        wr_reg(REG_SHIFT, tx);
        wr_reg(REG_TRIGGER, 8'h01);
        rd_reg(REG_STATUS, v);
        check(v & 8'h03, 8'h01);
        csa_partner_i.xfer(seed, got);
        check(got, tx);
        for (int k = 0; k < 3; k++) begin
            rxv[k] = seed;
            seed = lfsr(seed);
            csa_partner_i.xfer(rxv[k], got);
            check(got, bufv[k]);
        end
        wait_idle();
        rd_reg(REG_AUTO_COUNT, v);
        check(v, 8'h02);
        rd_reg(REG_IRQ_STATUS, v);
        check(v & 8'h02, 8'h02);
        rd_reg(REG_TRIGGER, v);
        check(v, 8'h00);
        wr_reg(REG_IRQ_STATUS, 8'h03);
        wr_reg(REG_BUF_ADDR, 8'h00);
        for (int k = 0; k < 3; k++) begin
            rd_reg(REG_BUF_DATA, v);
            check(v, rxv[k]);
        end
        // Stop requested during the first byte ends the run after that byte.
        wr_reg(REG_AUTO_LAST, 8'h03);
        wr_reg(REG_TRIGGER, 8'h01);
        wr_reg(REG_TRIGGER, 8'h03);
        csa_partner_i.xfer(seed, got);
        // The earlier run stored its received bytes, so the buffer now holds those.
        check(got, rxv[0]);
        wait_idle();
        rd_reg(REG_AUTO_COUNT, v);
        check(v, 8'h00);
        rd_reg(REG_TRIGGER, v);
        check(v, 8'h00);
        rd_reg(REG_IRQ_STATUS, v);
        check(v & 8'h02, 8'h02);
        check({7'h00, irq}, 8'h01);
        wr_reg(REG_IRQ_MASK, 8'h00);
        #1;
        check({7'h00, irq}, 8'h00);
        wr_reg(REG_MODE, 8'h00);
        rd_reg(REG_DIVISOR, v);
        check(v, 8'h00);
        rd_reg(REG_AUTO_LAST, v);
        check(v, 8'h00);
        rd_reg(REG_MODE, v);
        check(v, 8'h00);
        rd_reg(REG_INTERVAL, v);
        check(v, 8'h00);
        results();
    end
endmodule
